// file: hw/arrp_top.sv
// arrp_top: result register, parallel byte port and serial shifter.
// assumes control pins asynchronous to clk and the shift clock pin as a
// second domain; the conversion engine supplies adc_code on clk.
//
// Function
// - format_select high gives offset binary, low gives two's complement.
// - parallel reads never disturb the stored result.
// - each internal shift clock pulse, and each external one with chip select low and read/convert high, moves the serial word one bit.
// - two's complement codes 7FFF, 0000, FFFF, 8000 from top to bottom.
// - offset binary codes FFFF, 8000, 7FFF, 0000 from top to bottom.
// - bus driven only with read/convert high and chip select low.
// - 16-bit result leaves the parallel bus as two bytes.
// - byte_sel low gives upper byte, high gives lower byte.
// - parallel contents before the first conversion are undefined.
// - result register updates, then busy rises with the new result.
// - previous result stays readable early in a conversion.
// - busy falls soon after a conversion start.
// - new data valid on the bus within 2.5 us of the start.
// - serial output is always driven.
// - external mode shifts with chip select low, read/convert high.
// - external mode makes shift clock an input; conversion stays internal.
// - start requests are ignored while busy is low.
// - chain input feeds the serial shifter for daisy chains.
// - internal mode emits 16 shift clock pulses, previous result, MSB first.
// - first chain bit appears on the 17th falling shift clock edge.

module arrp_top #(
	parameter int CONV_CYCLES = arrp_pkg::CONV_CYC
) (
	input  wire logic                    clk,
	input  wire logic                    rstn,
	input  wire arrp_pkg::arrp_pins_t    ctrl,
	input  wire logic [15:0]             adc_code,
	input  wire logic                    chain_in,
	input  wire logic                    shift_clock_i,
	output logic                         shift_clock_o,
	output logic                         shift_clock_oe,
	output logic                         serial_out_line,
	output logic [7:0]                   parallel_data_bus_o,
	output logic                         parallel_data_bus_oe,
	output logic                         busy
);

	localparam int BITS  = arrp_pkg::RES_W;
	localparam int CW    = $clog2(CONV_CYCLES + 1);
	localparam int PH_W  = 3;
	localparam int BC_W  = $clog2(BITS + 1);

	// the serial word must be done before the conversion ends
	if (CONV_CYCLES < 2 * arrp_pkg::SCK_HALF_CYC * (BITS + 1)
		+ arrp_pkg::SER_CLR_CYC) begin : g_chk
		$error("CONV_CYCLES too small for the internal serial transfer");
	end

	// the parallel port splits each word into exactly two bytes
	if (BITS != 2 * arrp_pkg::BYTE_W) begin : g_chk_bytes
		$error("result width must be two bytes");
	end

	// the first shift clock delay has to fit the phase counter
	if (arrp_pkg::SER_CLR_CYC + arrp_pkg::SCK_HALF_CYC
		>= 2 ** PH_W) begin : g_chk_phase
		$error("PH_W too narrow for the first shift clock delay");
	end

	// the link clear length lives in a two-bit counter
	if (arrp_pkg::SER_CLR_CYC < 1
		|| arrp_pkg::SER_CLR_CYC > 3) begin : g_chk_clr
		$error("SER_CLR_CYC must fit the two-bit clear counter");
	end

	////////////////////////////////////////////////////////////////////////
	// reset release and pin synchronisers

	logic [1:0] rst_q;
	logic       rst_n_s;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rst_q <= 2'b00;
		end else begin
			rst_q <= {rst_q[0], 1'b1};
		end
	end

	assign rst_n_s = rst_q[1];

	logic [arrp_pkg::PINS_W-1:0] s1_q;
	logic [arrp_pkg::PINS_W-1:0] s2_q;
	logic [arrp_pkg::PINS_W-1:0] s3_q;
	logic [arrp_pkg::PINS_W-1:0] filt_q;
	logic [arrp_pkg::PINS_W-1:0] filt_d;

	// a level counts once the second and third stage agree
	for (genvar i = 0; i < arrp_pkg::PINS_W; i++) begin : g_sync
		always_ff @(posedge clk or negedge rst_n_s) begin
			if (!rst_n_s) begin
				s1_q[i]   <= arrp_pkg::PINS_RST[i];
				s2_q[i]   <= arrp_pkg::PINS_RST[i];
				s3_q[i]   <= arrp_pkg::PINS_RST[i];
				filt_q[i] <= arrp_pkg::PINS_RST[i];
			end else begin
				s1_q[i]   <= ctrl[i];
				s2_q[i]   <= s1_q[i];
				s3_q[i]   <= s2_q[i];
				filt_q[i] <= filt_d[i];
			end
		end
		assign filt_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : filt_q[i];
	end

	arrp_pkg::arrp_pins_t pins;
	assign pins = arrp_pkg::arrp_pins_t'(filt_q);

	////////////////////////////////////////////////////////////////////////
	// conversion sequencing, result register and pin outputs

	arrp_pkg::arrp_state_t state_q, state_d;
	logic [CW-1:0]    conv_cnt_q, conv_cnt_d;
	logic [15:0]      sample_q, sample_d;
	logic [15:0]      result_q, result_d;
	logic             busy_q, busy_d;
	logic [1:0]       clr_cnt_q, clr_cnt_d;
	logic             link_clr_q, link_clr_d;
	logic [BC_W-1:0]  pulses_q, pulses_d;
	logic [PH_W-1:0]  phase_q, phase_d;
	logic             sck_q, sck_d;
	logic             sck_oe_q, sck_oe_d;
	logic             gate_q, gate_d;
	logic [7:0]       pd_q, pd_d;
	logic             pd_oe_q, pd_oe_d;
	logic             start_req;

	always_comb begin
		state_d    = state_q;
		conv_cnt_d = conv_cnt_q;
		sample_d   = sample_q;
		result_d   = result_q;
		busy_d     = busy_q;
		clr_cnt_d  = (clr_cnt_q != 2'd0) ? clr_cnt_q - 2'd1 : 2'd0;
		pulses_d   = pulses_q;
		phase_d    = phase_q;
		sck_d      = sck_q;
		// chip select and read/convert are ORed and level sensitive
		start_req  = !pins.cs_n && !pins.rc_n;
		unique case (state_q)
			arrp_pkg::ARRP_IDLE: begin
				// a start still held when busy rises begins another one
				if (start_req) begin
					state_d    = arrp_pkg::ARRP_CONV;
					busy_d     = 1'b0;
					conv_cnt_d = CW'(CONV_CYCLES - 1);
					sample_d   = adc_code;
					if (!pins.ext_clock_select) begin
						// previous result leaves serially during conversion
						clr_cnt_d = 2'(arrp_pkg::SER_CLR_CYC);
						pulses_d  = BC_W'(BITS);
						phase_d   = PH_W'(arrp_pkg::SER_CLR_CYC
							+ arrp_pkg::SCK_HALF_CYC);
					end
				end
			end
			arrp_pkg::ARRP_CONV: begin
				// result_q holds the previous word until here
				if (conv_cnt_q != '0) begin
					conv_cnt_d = conv_cnt_q - CW'(1);
				end else if (pulses_q == '0) begin
					state_d  = arrp_pkg::ARRP_DONE;
					// engine gives offset binary; flip msb for two's comp
					result_d = pins.format_select ? sample_q
						: sample_q ^ arrp_pkg::MIDSCALE_FLIP;
					clr_cnt_d = 2'(arrp_pkg::SER_CLR_CYC);
				end
			end
			arrp_pkg::ARRP_DONE: begin
				// busy rises one edge after the update, with the bus
				state_d = arrp_pkg::ARRP_IDLE;
				busy_d  = 1'b1;
			end
		endcase
		// start requests outside idle fall through untouched
		if (pulses_q != '0) begin
			if (phase_q != '0) begin
				phase_d = phase_q - PH_W'(1);
			end else begin
				phase_d = PH_W'(arrp_pkg::SCK_HALF_CYC - 1);
				sck_d   = !sck_q;
				if (sck_q) begin
					pulses_d = pulses_q - BC_W'(1);
				end
			end
		end
		link_clr_d = (clr_cnt_d != 2'd0);
		sck_oe_d   = !pins.ext_clock_select;
		gate_d     = !pins.ext_clock_select
			|| (!pins.cs_n && pins.rc_n);
		pd_oe_d    = !pins.cs_n && pins.rc_n;
		pd_d       = pins.byte_sel ? result_q[7:0]
			: result_q[15:8];
	end

	always_ff @(posedge clk or negedge rst_n_s) begin
		if (!rst_n_s) begin
			state_q    <= arrp_pkg::ARRP_IDLE;
			conv_cnt_q <= '0;
			sample_q   <= arrp_pkg::RESULT_RST;
			// contents mean nothing until a conversion completes
			result_q   <= arrp_pkg::RESULT_RST;
			busy_q     <= 1'b1;
			clr_cnt_q  <= 2'd0;
			link_clr_q <= 1'b1;
			pulses_q   <= '0;
			phase_q    <= '0;
			sck_q      <= 1'b0;
			sck_oe_q   <= 1'b0;
			gate_q     <= 1'b0;
			pd_q       <= 8'h00;
			pd_oe_q    <= 1'b0;
		end else begin
			state_q    <= state_d;
			conv_cnt_q <= conv_cnt_d;
			sample_q   <= sample_d;
			result_q   <= result_d;
			busy_q     <= busy_d;
			clr_cnt_q  <= clr_cnt_d;
			link_clr_q <= link_clr_d;
			pulses_q   <= pulses_d;
			phase_q    <= phase_d;
			sck_q      <= sck_d;
			sck_oe_q   <= sck_oe_d;
			gate_q     <= gate_d;
			pd_q       <= pd_d;
			pd_oe_q    <= pd_oe_d;
		end
	end

	// parallel reads only look at result_q, so it can be read again
	assign parallel_data_bus_o  = pd_q;
	assign parallel_data_bus_oe = pd_oe_q;
	assign busy                 = busy_q;
	assign shift_clock_o        = sck_q;
	assign shift_clock_oe       = sck_oe_q;

	////////////////////////////////////////////////////////////////////////
	// link side, clocked by the shift clock pin in either mode
	// result_q and gate_q are quiet while the host shifts; link_clr_q
	// restarts the word by asynchronous clear, so no edge is spent on it.
	// shifting near the update loses data, as for the real part.

	logic             chain_q;
	logic [BC_W-1:0]  lk_cnt_q, lk_cnt_d;
	logic [BITS-1:0]  tag_q, tag_d;
	logic             sout_q, sout_d;
	logic [BITS-1:0]  word_sh;

	always_ff @(posedge shift_clock_i or posedge link_clr_q) begin
		if (link_clr_q) begin
			chain_q <= 1'b0;
		end else begin
			chain_q <= chain_in;
		end
	end

	always_comb begin
		lk_cnt_d = lk_cnt_q;
		tag_d    = tag_q;
		sout_d   = sout_q;
		word_sh  = result_q << lk_cnt_q;
		if (gate_q) begin
			// word bits first, then chain bits 16 pulses late
			sout_d = (lk_cnt_q < BC_W'(BITS)) ? word_sh[BITS-1]
				: tag_q[BITS-1];
			tag_d  = {tag_q[BITS-2:0], chain_q};
			if (lk_cnt_q < BC_W'(BITS)) begin
				lk_cnt_d = lk_cnt_q + BC_W'(1);
			end
		end
	end

	always_ff @(negedge shift_clock_i or posedge link_clr_q) begin
		if (link_clr_q) begin
			lk_cnt_q <= '0;
			tag_q    <= '0;
			sout_q   <= 1'b0;
		end else begin
			lk_cnt_q <= lk_cnt_d;
			tag_q    <= tag_d;
			sout_q   <= sout_d;
		end
	end

	// no enable exists: the serial line is driven at all times
	assign serial_out_line = sout_q;

endmodule : arrp_top

// file: hw/arrp_pkg.sv
// arrp_pkg: constants and types of the conversion result readout port.
// assumes a 40 MHz system clock and a 16-bit offset-binary code from the
// conversion engine.
package arrp_pkg;

	localparam int RES_W         = 16;
	localparam int BYTE_W        = 8;
	localparam int CLK_PERIOD_NS = 25;

	// conversion time, longest figure rounded down to whole cycles
	localparam int CONV_TIME_NS  = 2200;
	localparam int CONV_CYC      = CONV_TIME_NS / CLK_PERIOD_NS;

	// internal shift clock: least cycle time, half period rounded up
	localparam int INT_SCK_NS    = 92;
	localparam int SCK_HALF_CYC  =
		(INT_SCK_NS / 2 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// cycles the link-side clear is held after a new word
	localparam int SER_CLR_CYC   = 2;

	localparam logic [15:0] MIDSCALE_FLIP = 16'h8000;
	localparam logic [15:0] RESULT_RST    = 16'h0000;

	typedef struct packed {
		logic ext_clock_select;
		logic format_select;
		logic byte_sel;
		logic rc_n;
		logic cs_n;
	} arrp_pins_t;

	localparam int PINS_W = $bits(arrp_pins_t);
	localparam arrp_pins_t PINS_RST = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1};

	typedef enum logic [1:0] {
		ARRP_IDLE,
		ARRP_CONV,
		ARRP_DONE
	} arrp_state_t;

endpackage : arrp_pkg

// file: test/arrp_host_model.sv
// arrp_host_model: host end of the serial link.
// assumes the device drives the clock pin while its enable is high.
module arrp_host_model (
	input wire logic sck_o,
	input wire logic sck_oe,
	input wire logic sdo,
	output logic     sck_i
);
	timeunit 1ns;
	timeprecision 100ps;
	logic        ext_sck = 1'b0;
	logic [31:0] rx      = 32'h0000_0000;
	// pin resolved from both drivers; host side rests low between bursts
	assign sck_i = sck_oe ? sck_o : ext_sck;
	// sample after each fall, once the new bit has left the device
	always begin
		@(negedge sck_i);
		#2;
		rx = {rx[30:0], sdo};
	end
	task automatic burst(input int n);
		rx = 32'h0000_0000;
		// period 105 ns, high 55 ns: below 10 MHz, about half high
		repeat (n) begin
			#50 ext_sck = 1'b1;
			#55 ext_sck = 1'b0;
		end
	endtask : burst
endmodule : arrp_host_model

// file: test/arrp_checker.sv
// arrp_checker: port assertions of the readout port.
// assumes pins settle through the input filter within 8 clk.
module arrp_checker #(
	parameter int CONV_CYCLES = arrp_pkg::CONV_CYC
) (
	input wire logic                 clk,
	input wire logic                 rstn,
	input wire arrp_pkg::arrp_pins_t ctrl,
	input wire logic                 shift_clock_o,
	input wire logic                 shift_clock_oe,
	input wire logic [7:0]           parallel_data_bus_o,
	input wire logic                 parallel_data_bus_oe,
	input wire logic                 busy
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn);
	////////////////////////////////////////
	logic [8:0] low_q, low_d;
	always_comb low_d = busy ? 9'h000 : low_q + 9'h001;
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) low_q <= 9'h000;
		else low_q <= low_d;
	end
	a_bus_cs_hiz: assert property (
		ctrl.cs_n [*8] |-> !parallel_data_bus_oe)
		else $error("bus on with cs high");
	a_bus_rc_hiz: assert property (
		!ctrl.rc_n [*8] |-> !parallel_data_bus_oe)
		else $error("bus on with rc low");
	a_busy_fall_soon: assert property (
		busy && !ctrl.cs_n && !ctrl.rc_n |-> ##[1:10] !busy)
		else $error("busy late");
	a_busy_low_len: assert property (
		$rose(busy) |-> low_q == CONV_CYCLES + 1)
		else $error("busy length");
	a_start_ignored: assert property (
		!busy && low_q < CONV_CYCLES |=> !busy)
		else $error("conversion cut short");
	a_sck_ext_input: assert property (
		ctrl.ext_clock_select [*8] |-> !shift_clock_oe)
		else $error("clock driven in ext mode");
	a_sck_idle_low: assert property (
		busy && shift_clock_oe |-> !shift_clock_o)
		else $error("clock runs idle");
	a_read_no_change: assert property (
		(busy && $stable(ctrl)) [*8] |-> $stable(parallel_data_bus_o))
		else $error("bus data moved");
	cover property ($rose(busy));
	cover property (parallel_data_bus_oe && ctrl.byte_sel);
	cover property ($rose(shift_clock_oe));
endmodule : arrp_checker
bind arrp_top arrp_checker #(.CONV_CYCLES(CONV_CYCLES)) u_chk (
	.clk(clk), .rstn(rstn), .ctrl(ctrl),
	.shift_clock_o(shift_clock_o), .shift_clock_oe(shift_clock_oe),
	.parallel_data_bus_o(parallel_data_bus_o),
	.parallel_data_bus_oe(parallel_data_bus_oe), .busy(busy)
);

// file: test/test_adc_result_readout_port.sv
// test_adc_result_readout_port: parallel and serial readout tests.
// assumes arrp_top with a longer conversion count (136 cycles) and the host model.
module test_adc_result_readout_port;
	timeunit 1ns;
	timeprecision 100ps;
	logic                 clk     = 1'b0;
	logic                 rstn    = 1'b0;
	logic                 chain   = 1'b0;
	logic                 prev_ok = 1'b0;
	logic [15:0]          code    = 16'h0000;
	logic [15:0]          prev    = 16'h0000;
	logic [15:0]          codes[4] = '{16'hFFFF, 16'h8000, 16'h7FFF, 16'h0000};
	arrp_pkg::arrp_pins_t ctrl    = arrp_pkg::PINS_RST;
	logic                 sck_o, sck_oe, sck_i, sdo, oe, busy;
	logic [7:0]           bus;
	int                   error_cnt   = 0;
	int                   checks_done = 0;
	////////////////////////////////////////
	arrp_top #(.CONV_CYCLES(136)) u_dut (
		.clk(clk), .rstn(rstn), .ctrl(ctrl), .adc_code(code),
		.chain_in(chain), .shift_clock_i(sck_i), .shift_clock_o(sck_o),
		.shift_clock_oe(sck_oe), .serial_out_line(sdo),
		.parallel_data_bus_o(bus), .parallel_data_bus_oe(oe), .busy(busy)
	);
	arrp_host_model u_host (
		.sck_o(sck_o), .sck_oe(sck_oe), .sdo(sdo), .sck_i(sck_i)
	);
	initial begin
		forever #12.5 clk = ~clk;
	end
	////////////////////////////////////////
	task automatic tick(input int n);
		repeat (n) @(negedge clk);
	endtask : tick
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic conclude;
		if (error_cnt == 0 && checks_done > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : conclude
	task automatic wait_busy(input logic lvl);
		for (int i = 0; i < 400 && busy !== lvl; i++) tick(1);
		chk(busy, lvl);
	endtask : wait_busy
	task automatic rd(input logic [15:0] e);
		ctrl.byte_sel = 1'b0;
		tick(6);
		chk({oe, bus}, {1'b1, e[15:8]});
		ctrl.byte_sel = 1'b1;
		tick(6);
		chk({oe, bus}, {1'b1, e[7:0]});
	endtask : rd
	task automatic conv(input logic [15:0] c);
		code = c;
		ctrl.cs_n = 1'b0;
		ctrl.rc_n = 1'b0;
		wait_busy(1'b0);
		ctrl.rc_n = 1'b1;
		tick(8);
		if (prev_ok) rd(prev);
		// a second start while converting must be ignored
		ctrl.rc_n = 1'b0;
		tick(8);
		ctrl.rc_n = 1'b1;
		wait_busy(1'b1);
		tick(8);
		chk(busy, 1'b1);
	endtask : conv
	////////////////////////////////////////
	initial begin
		tick(2);
		rstn = 1'b1;
		tick(2);
		conv(16'h1234);
		for (int f = 0; f < 2; f++) begin
			ctrl.format_select = f[0];
			prev_ok = 1'b0;
			foreach (codes[i]) begin
				conv(codes[i]);
				prev = f[0] ? codes[i] : codes[i] ^ 16'h8000;
				rd(prev);
				rd(prev);
				prev_ok = 1'b1;
			end
		end
		chain = 1'b1;
		conv(16'hA5C3);
		rd(16'hA5C3);
		u_host.burst(18);
		tick(1);
		chk(u_host.rx[17:0], {16'hA5C3, 2'b11});
		ctrl.ext_clock_select = 1'b0;
		prev_ok = 1'b0;
		tick(8);
		u_host.rx = 32'h0000_0000;
		conv(16'h0F0F);
		chk(u_host.rx[15:0], 16'hA5C3);
		ctrl.cs_n = 1'b1;
		ctrl.rc_n = 1'b0;
		tick(8);
		chk({oe, busy}, 2'b01);
		chk((^sdo) === 1'bx, 1'b0);
		conclude();
	end
	initial begin
		#200_000;
		error_cnt++;
		conclude();
	end
endmodule : test_adc_result_readout_port
